// ===== design/sleep_power_pkg.sv
// Constants and carriers shared by the sleep and wake controller.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package sleep_power_pkg;
  // ==========================================================
  // Sleep mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PIN = 3'h1;
  localparam logic [2:0] MODE_CYCLIC = 3'h4;
  localparam logic [2:0] MODE_CYCLIC_PIN = 3'h5;
  // ==========================================================
  // Pin function and option fields
  localparam logic [2:0] PIN_FUNC_PERIPHERAL = 3'h1;
  localparam int DORMANCY_OPTION_BIT = 3;
  localparam logic [7:0] ASSOC_DORMANT = 8'h2C;
  localparam logic [7:0] ASSOC_READY = 8'h00;
  // Default pin function of the sleep request pin after reset
  localparam logic [2:0] SLEEP_PIN_FUNC_RESET = 3'h1;
  // ==========================================================
  // Timing
  localparam int CLOCK_HZ = 10000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * (CLOCK_HZ / 1000000);
  localparam int PREP_TICKS = 4;

  // Configuration carrier
  typedef struct packed {
    logic [2:0] sleep_mode_select;
    logic [2:0] sleep_pin_function_cfg;
    logic [2:0] select_pin_function_cfg;
    logic [7:0] device_options;
    logic airplane_control;
  } config_type;

  // Pending network requests carrier
  typedef struct packed {
    logic [7:0] requested_active_timer;
    logic [7:0] requested_area_update_timer;
  } timer_request_type;

  typedef enum logic [4:0] {
    ST_AWAKE = 5'b00001,
    ST_PREPARE = 5'b00010,
    ST_ASLEEP = 5'b00100,
    ST_DEEP = 5'b01000,
    ST_WAKING = 5'b10000
  } sleep_state_type;
endpackage

// ===== design/sleep_wake_power_control.sv
// Sleep and wake controller: pin sleep source select, cyclic sleep,
// sleep timer, airplane mode and cellular dormancy tracking.
// Assumes host pins are synchronous to mclk and config is static-ish.
`timescale 1ns/1ns

module sleep_wake_power_control
  import sleep_power_pkg::*;
#(
  parameter int AWAKE_TICKS = 16,
  parameter int SLEEP_TICKS = 64
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Host pins
  input wire logic sleep_request_pin,
  input wire logic spi_select_pin,
  // Configuration
  input wire config_type cfg,
  input wire logic cfg_write,
  input wire timer_request_type timer_req,
  // Cellular component status
  input wire logic cell_dormant_entered,
  input wire logic cell_activity_local,
  input wire timer_request_type timer_granted,
  input wire logic timer_granted_valid,
  // Status and control outputs
  output logic module_asleep,
  output logic low_power_entry,
  output logic cellular_power_on,
  output logic network_allowed,
  output logic close_datagrams,
  output logic close_streams,
  output logic cancel_pending,
  output logic script_suspend,
  output logic dormancy_enable,
  output logic [7:0] association_indication,
  output logic pin_sleep_source_valid,
  output timer_request_type timer_to_network,
  output timer_request_type timer_in_use
);
  // Refuse tick counts that the 16-bit timer cannot hold
  if (AWAKE_TICKS < 1 || SLEEP_TICKS < 1
      || AWAKE_TICKS > 65535 || SLEEP_TICKS > 65535) begin : g_bad_ticks
    $error("tick counts out of range");
  end

  localparam logic [15:0] AWAKE_LEN = 16'(AWAKE_TICKS);
  localparam logic [15:0] SLEEP_LEN = 16'(SLEEP_TICKS);

  // ==========================================================
  // Pin synchronisers and tick divider
  logic [1:0] sync_sleep, sync_sel, next_sync_sleep, next_sync_sel;
  logic ctl_prev, next_ctl_prev;
  logic [15:0] div_cnt, next_div_cnt;
  logic tick, next_tick;

  // Second stage only is read beyond the synchroniser
  always_comb begin
    next_sync_sleep = {sync_sleep[0], sleep_request_pin};
    next_sync_sel = {sync_sel[0], spi_select_pin};
    next_div_cnt = (div_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    next_tick = (div_cnt == 16'(TICK_CYCLES - 1));
  end

  // Source selection: sleep pin wins when both are peripherals
  logic sel_sleep_pin, sel_select_pin, ctl_level, ctl_fall, src_valid;
  always_comb begin
    sel_sleep_pin = (cfg.sleep_pin_function_cfg == PIN_FUNC_PERIPHERAL);
    sel_select_pin = !sel_sleep_pin
      && (cfg.select_pin_function_cfg == PIN_FUNC_PERIPHERAL);
    src_valid = sel_sleep_pin || sel_select_pin;
    // High means sleep for either source; select low keeps awake
    ctl_level = sel_sleep_pin ? sync_sleep[1]
              : (sel_select_pin ? sync_sel[1] : 1'b0);
    ctl_fall = ctl_prev && !ctl_level;
    next_ctl_prev = ctl_level;
  end

  // ==========================================================
  // Sleep state machine
  sleep_state_type state, next_state;
  logic [15:0] timer, next_timer;
  logic early_return, next_early_return;
  logic next_module_asleep, next_low_power_entry, next_script_suspend;
  logic next_close_datagrams;

  // Preparation cannot be aborted; an early return only skips low power
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_early_return = early_return;
    next_close_datagrams = 1'b0;
    if (tick && timer != 16'h0000)
      next_timer = timer - 16'h0001;
    case (state)
      ST_AWAKE: begin
        if (cfg_write)
          next_timer = AWAKE_LEN;
        if (cfg.sleep_mode_select == MODE_PIN && src_valid && ctl_level) begin
          next_state = ST_PREPARE;
          next_timer = 16'(PREP_TICKS);
          next_early_return = 1'b0;
        end else if ((cfg.sleep_mode_select == MODE_CYCLIC
                      || cfg.sleep_mode_select == MODE_CYCLIC_PIN)
                     && timer == 16'h0000) begin
          next_state = ST_PREPARE;
          next_timer = 16'(PREP_TICKS);
          next_early_return = 1'b0;
        end
      end
      ST_PREPARE: begin
        if (cfg.sleep_mode_select == MODE_PIN && !ctl_level)
          next_early_return = 1'b1;
        if (timer == 16'h0000) begin
          next_close_datagrams = 1'b1;
          if (next_early_return) begin
            next_state = ST_WAKING;
          end else begin
            next_state = (cfg.sleep_mode_select == MODE_PIN) ? ST_DEEP : ST_ASLEEP;
            next_timer = SLEEP_LEN;
          end
        end
      end
      ST_ASLEEP: begin
        if (timer == 16'h0000)
          next_state = ST_WAKING;
        else if (cfg.sleep_mode_select == MODE_CYCLIC_PIN && ctl_fall)
          next_state = ST_WAKING;
      end
      ST_DEEP: begin
        if (!ctl_level || cfg.sleep_mode_select != MODE_PIN)
          next_state = ST_WAKING;
      end
      ST_WAKING: begin
        next_state = ST_AWAKE;
        next_timer = AWAKE_LEN;
      end
      default: begin
        next_state = ST_AWAKE;
        next_timer = AWAKE_LEN;
      end
    endcase
    next_module_asleep = (next_state == ST_ASLEEP) || (next_state == ST_DEEP);
    next_low_power_entry = next_module_asleep;
    next_script_suspend = (next_state == ST_DEEP);
  end

  // ==========================================================
  // Cellular component and dormancy tracking
  logic dormant, next_dormant;
  logic next_cellular_power_on, next_network_allowed, next_dormancy_enable;
  logic next_close_streams, next_cancel_pending;
  logic [7:0] next_assoc;
  timer_request_type next_timer_in_use;

  always_comb begin
    next_dormancy_enable = cfg.device_options[DORMANCY_OPTION_BIT];
    next_dormant = dormant;
    next_close_streams = 1'b0;
    next_cancel_pending = 1'b0;
    // Module sleep alone never drives dormancy; only the modem reports it
    // A dormancy report in the same cycle as local activity wins; later activity wakes it
    if (!next_dormancy_enable || cfg.airplane_control)
      next_dormant = 1'b0;
    else if (cell_dormant_entered && !dormant) begin
      next_dormant = 1'b1;
      next_close_streams = 1'b1;
      next_cancel_pending = 1'b1;
    end else if (cell_activity_local)
      next_dormant = 1'b0;
    // Airplane mode powers the component off; deep sleep does too unless dormancy is enabled
    next_cellular_power_on = !cfg.airplane_control
      && (next_state != ST_DEEP || next_dormancy_enable);
    next_network_allowed = !cfg.airplane_control;
    next_assoc = next_dormant ? ASSOC_DORMANT : ASSOC_READY;
    next_timer_in_use = timer_granted_valid ? timer_granted : timer_in_use;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_sleep <= 2'h0;
      sync_sel <= 2'h0;
      ctl_prev <= 1'b0;
      div_cnt <= 16'h0000;
      tick <= 1'b0;
      state <= ST_AWAKE;
      timer <= AWAKE_LEN;
      early_return <= 1'b0;
      module_asleep <= 1'b0;
      low_power_entry <= 1'b0;
      script_suspend <= 1'b0;
      close_datagrams <= 1'b0;
      dormant <= 1'b0;
      cellular_power_on <= 1'b0;
      network_allowed <= 1'b0;
      dormancy_enable <= 1'b0;
      close_streams <= 1'b0;
      cancel_pending <= 1'b0;
      association_indication <= ASSOC_READY;
      pin_sleep_source_valid <= 1'b0;
      timer_to_network <= '0;
      timer_in_use <= '0;
    end else begin
      sync_sleep <= next_sync_sleep;
      sync_sel <= next_sync_sel;
      ctl_prev <= next_ctl_prev;
      div_cnt <= next_div_cnt;
      tick <= next_tick;
      state <= next_state;
      timer <= next_timer;
      early_return <= next_early_return;
      module_asleep <= next_module_asleep;
      low_power_entry <= next_low_power_entry;
      script_suspend <= next_script_suspend;
      close_datagrams <= next_close_datagrams;
      dormant <= next_dormant;
      cellular_power_on <= next_cellular_power_on;
      network_allowed <= next_network_allowed;
      dormancy_enable <= next_dormancy_enable;
      close_streams <= next_close_streams;
      cancel_pending <= next_cancel_pending;
      association_indication <= next_assoc;
      pin_sleep_source_valid <= src_valid;
      timer_to_network <= timer_req;
      timer_in_use <= next_timer_in_use;
    end
  end
endmodule

// ===== dv/host_pins.sv
// Host model: drives the sleep request and select pins.
// Assumes the bench gives mclk and the wanted pin levels.
`timescale 1ns/1ns
module host_pins (
  // Clock and wanted levels
  input wire logic mclk,
  input wire logic [1:0] want,
  // Pins
  output logic sleep_request_pin,
  output logic spi_select_pin
);
  // ==========
  // Pins move just after the edge, as a real host would
  initial {sleep_request_pin, spi_select_pin} = 2'h0;
  always @(posedge mclk) begin
    {sleep_request_pin, spi_select_pin} <= #2 want;
  end
endmodule

// ===== dv/swpc_sva.sv
// Checker for the sleep controller, bound to its top ports.
// Assumes one clock domain.
`timescale 1ns/1ns
module swpc_sva
  import sleep_power_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire config_type cfg,
  input wire timer_request_type timer_req,
  input wire timer_request_type timer_granted,
  input wire logic timer_granted_valid,
  input wire logic module_asleep,
  input wire logic low_power_entry,
  input wire logic cellular_power_on,
  input wire logic network_allowed,
  input wire logic close_datagrams,
  input wire logic close_streams,
  input wire logic cancel_pending,
  input wire logic script_suspend,
  input wire logic dormancy_enable,
  input wire logic [7:0] association_indication,
  input wire timer_request_type timer_to_network,
  input wire timer_request_type timer_in_use
);
  // ==========
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_airplane_off: assert property (
    cfg.airplane_control && $past(cfg.airplane_control) |-> !network_allowed && !cellular_power_on)
    else $error("cellular on in airplane mode");
  a_dormancy_bit: assert property (
    !$past(sys_rst) && $stable(cfg.device_options[3]) |-> dormancy_enable == cfg.device_options[3])
    else $error("dormancy enable wrong");
  a_assoc_code: assert property (
    association_indication != 8'h00 |-> association_indication == 8'h2C && dormancy_enable)
    else $error("bad association code");
  a_lowpower_same: assert property (low_power_entry == module_asleep)
    else $error("low power entry differs");
  a_datagram_pulse: assert property (close_datagrams |=> !close_datagrams)
    else $error("datagram close not a pulse");
  a_stream_cancel: assert property (
    close_streams |-> cancel_pending ##1 !close_streams)
    else $error("stream close without cancel");
  a_timer_forward: assert property (
    !$past(sys_rst) |-> timer_to_network == $past(timer_req))
    else $error("timer request not forwarded");
  a_grant_latch: assert property (
    timer_granted_valid |=> timer_in_use == $past(timer_granted))
    else $error("granted timers not taken");
  a_suspend_sleep: assert property (script_suspend |-> module_asleep)
    else $error("script suspended while awake");
endmodule

// ===== dv/tb.sv
// Bench for the sleep and wake controller.
// Assumes host_pins and swpc_sva are compiled before it.
`timescale 1ns/1ns
module tb;
  import sleep_power_pkg::*;
  logic mclk = 0, sys_rst = 1, cfg_write = 0, timer_granted_valid = 0;
  logic cell_dormant_entered = 0, cell_activity_local = 0, seen;
  logic [1:0] want = 2'h0;
  logic sleep_request_pin, spi_select_pin, module_asleep, low_power_entry;
  logic cellular_power_on, network_allowed, close_datagrams, close_streams;
  logic cancel_pending, script_suspend, dormancy_enable, pin_sleep_source_valid;
  logic [7:0] association_indication;
  config_type cfg = '0;
  timer_request_type timer_req = '0, timer_granted = '0, timer_to_network, timer_in_use;
  int num_errors = 0, n_tests = 0, cycles = 0, n;
  host_pins i_host (.mclk, .want, .sleep_request_pin, .spi_select_pin);
  sleep_wake_power_control #(.AWAKE_TICKS(2), .SLEEP_TICKS(2)) i_dut (.mclk, .sys_rst,
    .sleep_request_pin, .spi_select_pin, .cfg, .cfg_write, .timer_req, .cell_dormant_entered,
    .cell_activity_local, .timer_granted, .timer_granted_valid, .module_asleep, .low_power_entry,
    .cellular_power_on, .network_allowed, .close_datagrams, .close_streams, .cancel_pending,
    .script_suspend, .dormancy_enable, .association_indication, .pin_sleep_source_valid,
    .timer_to_network, .timer_in_use);
  // ==========
  // Clock and hang guard; the run needs about 80000 cycles
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  // ==========
  // Helpers
  task automatic step(int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  function automatic logic exp_src(config_type c);
    return c.sleep_pin_function_cfg == PIN_FUNC_PERIPHERAL
      || c.select_pin_function_cfg == PIN_FUNC_PERIPHERAL;
  endfunction
  // Preparation spans PREP_TICKS ticks; the first tick may be partial
  function automatic logic prep_ok(int cycles_seen);
    return cycles_seen >= (PREP_TICKS - 1) * TICK_CYCLES
      && cycles_seen <= PREP_TICKS * TICK_CYCLES + 10;
  endfunction
  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Wait for close_datagrams or module_asleep, counting cycles so the length can be judged
  task automatic wait_flag(logic use_asleep);
    n = 0;
    seen = 0;
    while (!(use_asleep ? module_asleep : close_datagrams) && n < 45000) begin
      step(1);
      n++;
      if (n == 5 && want == 2'h1) want = 2'h0;
      seen |= module_asleep;
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h7E02));
    step(3);
    sys_rst = 0;
    chk("asleep_rst", 0, module_asleep);
    // Random configs in normal mode, mixing corner pin settings
    for (int i = 0; i < 20; i++) begin
      cfg = config_type'(18'($urandom));
      cfg.sleep_mode_select = MODE_NORMAL;
      if (i < 4) {cfg.sleep_pin_function_cfg, cfg.select_pin_function_cfg} = {2'h0, i[1], 2'h0, i[0]};
      timer_req = timer_request_type'(16'($urandom));
      timer_granted = timer_request_type'(16'($urandom));
      {cfg_write, timer_granted_valid} = 2'h3;
      step(1);
      {cfg_write, timer_granted_valid} = 2'h0;
      step(2);
      chk("net", !cfg.airplane_control, network_allowed);
      chk("dorm_en", cfg.device_options[3], dormancy_enable);
      chk("src", exp_src(cfg), pin_sleep_source_valid);
      chk("to_net", timer_req, timer_to_network);
      chk("in_use", timer_granted, timer_in_use);
    end
    // Dormancy entry and local wake
    cfg = '0;
    cfg.device_options = 8'h08;
    step(2);
    cell_dormant_entered = 1;
    step(1);
    cell_dormant_entered = 0;
    chk("close_streams", 1, close_streams);
    chk("cancel_pending", 1, cancel_pending);
    step(4);
    chk("assoc_dorm", 8'h2C, association_indication);
    cell_activity_local = 1;
    step(1);
    cell_activity_local = 0;
    step(4);
    chk("assoc_wake", 8'h00, association_indication);
    // Select pin: short high still runs full preparation, no low power
    cfg.sleep_mode_select = MODE_PIN;
    cfg.select_pin_function_cfg = 3'h1;
    step(2);
    want = 2'h1;
    wait_flag(1'b0);
    chk("prep_len", 1, prep_ok(n));
    chk("no_lowpower", 0, seen);
    // Sleep pin outranks select pin; cellular kept on for dormancy
    cfg.sleep_pin_function_cfg = 3'h1;
    step(20);
    want = 2'h2;
    wait_flag(1'b1);
    chk("sleep_len", 1, prep_ok(n));
    chk("lowpower", 1, low_power_entry);
    chk("suspend", 1, script_suspend);
    chk("cell_on", 1, cellular_power_on);
    want = 2'h0;
    step(10);
    chk("woken", 0, module_asleep);
    chk("lowpower_off", 0, low_power_entry);
    tally_and_finish;
  end
endmodule
bind sleep_wake_power_control swpc_sva i_sva (.mclk, .sys_rst, .cfg, .timer_req, .timer_granted,
  .timer_granted_valid, .module_asleep, .low_power_entry, .cellular_power_on, .network_allowed,
  .close_datagrams, .close_streams, .cancel_pending, .script_suspend, .dormancy_enable,
  .association_indication, .timer_to_network, .timer_in_use);
